// file: hdl/ris_defs.svh
`ifndef RIS_DEFS_SVH
`define RIS_DEFS_SVH

// Register addresses
`define RIS_ADDR_PRIO 8'h14
`define RIS_ADDR_CTL 8'h15
`define RIS_ADDR_HOLDOFF 8'h16
`define RIS_ADDR_CFG 8'h17
`define RIS_ADDR_STATUS 8'h1D

// Reset values
`define RIS_PRIO_RST 8'hE4
`define RIS_CTL_RST 8'h00
`define RIS_HOLDOFF_RST 8'h80
`define RIS_CFG_RST 8'h82
`define RIS_REVAL_RST 7'h20

// Field positions
`define RIS_CTL_MASK_BIT 6
`define RIS_CTL_PREDIV_BIT 5
`define RIS_CTL_REVERTIVE_ENABLE_BIT 4
`define RIS_CTL_MODE_LSB 2
`define RIS_CTL_PICK_LSB 0
`define RIS_CFG_PRESCALE_LSB 6
`define RIS_CFG_PD_LSB 2
`define RIS_CFG_REVAL_LSB 0
`define RIS_STATUS_STICKY_BIT 6

// Timing counts
`define RIS_PRESCALE_BASE_LOG2 15
`define RIS_REVAL_BASE 7'h08
`define RIS_MISS_CYCLES 64

`endif

// file: hdl/ris_pkg.sv
package ris_pkg;

  typedef enum logic [1:0] {
    RIS_MODE_MANUAL = 2'b00,
    RIS_MODE_AUTO = 2'b01,
    RIS_MODE_SHORT_HOLD = 2'b10,
    RIS_MODE_AUTO_HOLD = 2'b11
  } ris_mode_t;

  typedef enum logic [1:0] {
    RIS_ST_MANUAL = 2'b00,
    RIS_ST_AUTO = 2'b01,
    RIS_ST_HOLDOFF = 2'b10
  } ris_state_t;

endpackage : ris_pkg

// file: hdl/ris_input_monitor.sv
`timescale 1ns/10ps
`include "ris_defs.svh"

module ris_input_monitor #(
  parameter int MISS_CYCLES = `RIS_MISS_CYCLES
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic ref_clk_i,
  input wire logic powerdown_i,
  input wire logic predivide_i,
  input wire logic [1:0] reval_count_i,
  output logic los_o
);

  logic s1_r, s2_r, s3_r, lvl_r;
  logic [1:0] div_r;
  logic [15:0] gap_r;
  logic [6:0] reval_r;
  logic rise, period_pulse, missing;
  logic [6:0] reval_load;

  assign reval_load = 7'(`RIS_REVAL_BASE << reval_count_i);
  assign rise = (s2_r == s3_r) && s3_r && !lvl_r;
  // Pre-divide only thins valid periods; the pin is still sampled at clk_i
  assign period_pulse = rise && (!predivide_i || div_r == 2'h3);
  // Gaps are timed per raw edge so the pre-divider cannot stretch the miss window
  assign missing = (gap_r == 16'(MISS_CYCLES - 1)) && !rise;

  always_ff @(posedge clk_i)
  begin
    s1_r <= ref_clk_i;
    s2_r <= s1_r;
    s3_r <= s2_r;
    if (srst_i)
      lvl_r <= 1'b0;
    else if (s2_r == s3_r)
      lvl_r <= s3_r;
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i || !predivide_i)
      div_r <= 2'h0;
    else if (rise)
      div_r <= div_r + 2'h1;
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i || rise || missing)
      gap_r <= 16'h0000;
    else
      gap_r <= gap_r + 16'h0001;
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      los_o <= 1'b1;
      reval_r <= `RIS_REVAL_RST;
    end
    else if (powerdown_i)
    begin
      los_o <= 1'b1;
      reval_r <= reval_load;
    end
    else if (!los_o)
    begin
      if (missing)
      begin
        los_o <= 1'b1;
        reval_r <= reval_load;
      end
    end
    else if (missing)
      reval_r <= reval_load;
    else if (period_pulse)
    begin
      if (reval_r <= 7'h01)
        los_o <= 1'b0;
      else
        reval_r <= reval_r - 7'h01;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  a_reval_clear: assert property ($fell(los_o) |-> $past(period_pulse) && $past(reval_r) <= 7'h01)
    else $error("input revalidated without finishing its count");

  a_miss_reload: assert property (los_o && missing && !powerdown_i |=> reval_r == $past(reval_load))
    else $error("missing edge did not reload revalidation count");

endmodule : ris_input_monitor

// file: hdl/ris_holdoff_timer.sv
`timescale 1ns/10ps
`include "ris_defs.svh"

module ris_holdoff_timer #(
  parameter int PRESCALE_BASE_LOG2 = `RIS_PRESCALE_BASE_LOG2
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic vcxo_clk_i,
  input wire logic run_i,
  input wire logic [1:0] prescale_i,
  input wire logic [7:0] load_i,
  output logic expire_o
);

  logic v1_r, v2_r, v3_r, vlvl_r;
  logic [19:0] pre_r;
  logic [7:0] cnt_r;
  logic vtick, step;

  assign vtick = (v2_r == v3_r) && v3_r && !vlvl_r;
  // Divider by two to the power base+prescale
  assign step = vtick && (pre_r == 20'((20'h1 << (PRESCALE_BASE_LOG2 + prescale_i)) - 1));

  always_ff @(posedge clk_i)
  begin
    v1_r <= vcxo_clk_i;
    v2_r <= v1_r;
    v3_r <= v2_r;
    if (srst_i)
      vlvl_r <= 1'b0;
    else if (v2_r == v3_r)
      vlvl_r <= v3_r;
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i || !run_i || step)
      pre_r <= 20'h00000;
    else if (vtick)
      pre_r <= pre_r + 20'h00001;
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      cnt_r <= `RIS_HOLDOFF_RST;
      expire_o <= 1'b0;
    end
    else if (!run_i)
    begin
      cnt_r <= load_i;
      expire_o <= 1'b0;
    end
    else if (step)
    begin
      if (cnt_r <= 8'h01)
      begin
        cnt_r <= load_i;
        expire_o <= 1'b1;
      end
      else
      begin
        cnt_r <= cnt_r - 8'h01;
        expire_o <= 1'b0;
      end
    end
    else
      expire_o <= 1'b0;
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  a_holdoff_reload: assert property (expire_o |-> cnt_r == $past(load_i))
    else $error("hold-off counter did not reload after expiry");

  a_expire_cause: assert property (expire_o |-> $past(step) && $past(run_i))
    else $error("hold-off expiry without a counted step");

endmodule : ris_holdoff_timer

// file: hdl/ris_reference_input_selector.sv
// What this block does
// - Mode field codes 00..11: manual, auto, short-term holdover, auto with holdover.
// - Modes 00 and 10 route the manually picked input to the loop.
// - Automatic modes choose the reference from loss states and priorities.
// - Pick code 00..11 selects input 0..3.
// - With the mode low bit set the manual pick is ignored.
// - Auto-with-holdover: hold-off counter counts down after reference loss.
// - Hold-off counter reaching zero triggers the fail-over switch.
// - Hold-off counter reloads from its setting after each zero.
// - Hold-off steps are VCXO pulses divided by prescaler; default count 0x80.
// - Prescale code 10 gives 1.066ms steps at 122.88 MHz VCXO.
// - On loss an input loads its revalidation count, decrements per valid period.
// - A missing edge during revalidation reloads the count.
// - Count at zero revalidates the input and clears its loss flag.
// - Per-input power-down bit: 0 enabled, 1 disabled.
// - Mask 0: lock-loss flags fire on lock loss or selected reference loss.
// - Mask 1: only true lock loss drives the lock-loss flags and lock pin.
// - Priority 00 lowest to 11 highest; ties favour the lower input number.
// - Revertive: a revalidated input re-selects only if it outranks current.
// - Pre-divide bit divides the input by four before revalidation counting.
`timescale 1ns/10ps
`include "ris_defs.svh"

module ris_reference_input_selector #(
  parameter int MISS_CYCLES = `RIS_MISS_CYCLES,
  parameter int PRESCALE_BASE_LOG2 = `RIS_PRESCALE_BASE_LOG2
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic [3:0] ref_clk_i,
  input wire logic vcxo_clk_i,
  input wire logic pll_lock_loss_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [7:0] reg_rdata_o,
  output logic [1:0] ref_select_o,
  output logic ref_switch_o,
  output logic [3:0] input_signal_loss_o,
  output logic vcxo_lock_loss_live_o,
  output logic vcxo_lock_loss_sticky_o,
  output logic lock_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Register file

  logic [7:0] prio_r, ctl_r, holdoff_count_value_r, cfg_r;
  logic sticky_clr;

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      prio_r <= `RIS_PRIO_RST;
      ctl_r <= `RIS_CTL_RST;
      holdoff_count_value_r <= `RIS_HOLDOFF_RST;
      cfg_r <= `RIS_CFG_RST;
    end
    else if (reg_we_i)
    begin
      case (reg_addr_i)
        `RIS_ADDR_PRIO: prio_r <= reg_wdata_i;
        `RIS_ADDR_CTL: ctl_r <= {1'b0, reg_wdata_i[6:0]};
        `RIS_ADDR_HOLDOFF: holdoff_count_value_r <= reg_wdata_i;
        `RIS_ADDR_CFG: cfg_r <= reg_wdata_i;
        default: ;
      endcase
    end
  end

  assign sticky_clr = reg_we_i && (reg_addr_i == `RIS_ADDR_STATUS)
    && reg_wdata_i[`RIS_STATUS_STICKY_BIT];

  ris_pkg::ris_mode_t reference_select_mode;
  logic [1:0] manual_pick, holdoff_prescale, revalidate_count;
  logic [3:0] input_powerdown;
  logic mask_ref_loss, revalidate_predivide, revertive_enable;

  // Control and config field decode
  assign reference_select_mode = ris_pkg::ris_mode_t'(ctl_r[`RIS_CTL_MODE_LSB +: 2]);
  assign manual_pick = ctl_r[`RIS_CTL_PICK_LSB +: 2];
  assign mask_ref_loss = ctl_r[`RIS_CTL_MASK_BIT];
  assign revalidate_predivide = ctl_r[`RIS_CTL_PREDIV_BIT];
  assign revertive_enable = ctl_r[`RIS_CTL_REVERTIVE_ENABLE_BIT];
  assign holdoff_prescale = cfg_r[`RIS_CFG_PRESCALE_LSB +: 2];
  assign input_powerdown = cfg_r[`RIS_CFG_PD_LSB +: 4];
  assign revalidate_count = cfg_r[`RIS_CFG_REVAL_LSB +: 2];

  ////////////////////////////////////////////////////////////////////////////
  // Per-input activity monitors

  logic [3:0] input_signal_loss, los_q_r, revalidated;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_mon
      // Pins pass three flops inside the monitor before any decision
      ris_input_monitor #(
        .MISS_CYCLES(MISS_CYCLES)
      ) u_mon (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .ref_clk_i(ref_clk_i[gi]),
        .powerdown_i(input_powerdown[gi]),
        .predivide_i(revalidate_predivide),
        .reval_count_i(revalidate_count),
        .los_o(input_signal_loss[gi])
      );
    end
  endgenerate

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      los_q_r <= 4'hF;
    else
      los_q_r <= input_signal_loss;
  end

  assign revalidated = los_q_r & ~input_signal_loss;

  ////////////////////////////////////////////////////////////////////////////
  // Best available input

  logic best_valid;
  logic [1:0] best_idx, best_prio, cur_prio;

  // Scan downward so that equal priority leaves the lower input chosen
  always_comb
  begin
    best_valid = 1'b0;
    best_idx = 2'h0;
    best_prio = 2'h0;
    for (int i = 3; i >= 0; i--)
    begin
      if (!input_signal_loss[i] && (!best_valid || prio_r[6 - 2 * i +: 2] >= best_prio))
      begin
        best_valid = 1'b1;
        best_idx = 2'(i);
        best_prio = prio_r[6 - 2 * i +: 2];
      end
    end
  end

  logic [1:0] sel_r;
  logic outranks, cur_lost, revert_req;

  assign cur_prio = prio_r[6 - 2 * sel_r +: 2];
  assign outranks = best_valid && ((best_prio > cur_prio)
    || (best_prio == cur_prio && best_idx < sel_r));
  assign cur_lost = input_signal_loss[sel_r];
  assign revert_req = revertive_enable && |(revalidated & ~(4'h1 << sel_r)) && outranks;

  ////////////////////////////////////////////////////////////////////////////
  // Selection state machine

  ris_pkg::ris_state_t state_r;
  logic holdoff_expire;

  ris_holdoff_timer #(
    .PRESCALE_BASE_LOG2(PRESCALE_BASE_LOG2)
  ) u_holdoff (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .vcxo_clk_i(vcxo_clk_i),
    .run_i(state_r == ris_pkg::RIS_ST_HOLDOFF),
    .prescale_i(holdoff_prescale),
    .load_i(holdoff_count_value_r),
    .expire_o(holdoff_expire)
  );

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      state_r <= ris_pkg::RIS_ST_MANUAL;
      sel_r <= 2'h0;
      ref_switch_o <= 1'b0;
    end
    else
    begin
      ref_switch_o <= 1'b0;
      case (state_r)
        ris_pkg::RIS_ST_MANUAL:
        begin
          if (reference_select_mode[0])
            state_r <= ris_pkg::RIS_ST_AUTO;
          else
          begin
            sel_r <= manual_pick;
            ref_switch_o <= (manual_pick != sel_r);
          end
        end
        ris_pkg::RIS_ST_AUTO:
        begin
          // Pick field unused here; the low mode bit keeps us out of manual
          if (!reference_select_mode[0])
            state_r <= ris_pkg::RIS_ST_MANUAL;
          else if (cur_lost)
          begin
            if (reference_select_mode == ris_pkg::RIS_MODE_AUTO_HOLD)
              state_r <= ris_pkg::RIS_ST_HOLDOFF;
            else if (best_valid)
            begin
              sel_r <= best_idx;
              ref_switch_o <= 1'b1;
            end
          end
          else if (revert_req)
          begin
            sel_r <= best_idx;
            ref_switch_o <= 1'b1;
          end
        end
        ris_pkg::RIS_ST_HOLDOFF:
        begin
          if (!reference_select_mode[0])
            state_r <= ris_pkg::RIS_ST_MANUAL;
          else if (!cur_lost || reference_select_mode != ris_pkg::RIS_MODE_AUTO_HOLD)
            state_r <= ris_pkg::RIS_ST_AUTO;
          else if (holdoff_expire && best_valid)
          begin
            // With nothing valid the counter reloads and retries later
            sel_r <= best_idx;
            ref_switch_o <= 1'b1;
            state_r <= ris_pkg::RIS_ST_AUTO;
          end
        end
        default:
          state_r <= ris_pkg::RIS_ST_MANUAL;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Lock-loss indications and status

  logic lol_nxt;

  assign lol_nxt = pll_lock_loss_i || (!mask_ref_loss && cur_lost);

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      vcxo_lock_loss_live_o <= 1'b0;
      lock_o <= 1'b0;
    end
    else
    begin
      vcxo_lock_loss_live_o <= lol_nxt;
      lock_o <= !lol_nxt;
    end
  end

  // Set beats clear so a loss in the clearing cycle is kept
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      vcxo_lock_loss_sticky_o <= 1'b0;
    else if (lol_nxt)
      vcxo_lock_loss_sticky_o <= 1'b1;
    else if (sticky_clr)
      vcxo_lock_loss_sticky_o <= 1'b0;
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      ref_select_o <= 2'h0;
      input_signal_loss_o <= 4'hF;
    end
    else
    begin
      ref_select_o <= sel_r;
      input_signal_loss_o <= input_signal_loss;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      reg_rdata_o <= 8'h00;
    else if (reg_re_i)
    begin
      case (reg_addr_i)
        `RIS_ADDR_PRIO: reg_rdata_o <= prio_r;
        `RIS_ADDR_CTL: reg_rdata_o <= ctl_r;
        `RIS_ADDR_HOLDOFF: reg_rdata_o <= holdoff_count_value_r;
        `RIS_ADDR_CFG: reg_rdata_o <= cfg_r;
        `RIS_ADDR_STATUS: reg_rdata_o <= {1'b0, vcxo_lock_loss_sticky_o, sel_r,
          input_signal_loss};
        default: reg_rdata_o <= 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  sequence s_manual_held;
    !reference_select_mode[0] ##1 !reference_select_mode[0];
  endsequence

  sequence s_hold_entered;
    state_r == ris_pkg::RIS_ST_AUTO && cur_lost
      && reference_select_mode == ris_pkg::RIS_MODE_AUTO_HOLD;
  endsequence

  a_manual_route: assert property (s_manual_held |=> sel_r == $past(manual_pick))
    else $error("manual mode did not route the picked input");

  a_auto_ignore: assert property ($changed(sel_r) && $past(state_r) != ris_pkg::RIS_ST_MANUAL
    |-> ref_switch_o)
    else $error("automatic selection changed without a switch");

  a_auto_failover: assert property (state_r == ris_pkg::RIS_ST_AUTO && cur_lost && best_valid
    && reference_select_mode == ris_pkg::RIS_MODE_AUTO |=> sel_r == $past(best_idx))
    else $error("automatic mode did not fail over to best input");

  a_holdoff_wait: assert property (s_hold_entered |=> state_r == ris_pkg::RIS_ST_HOLDOFF
    ##0 $stable(sel_r))
    else $error("holdover mode switched without waiting");

  a_holdoff_switch: assert property (state_r == ris_pkg::RIS_ST_HOLDOFF && holdoff_expire
    && cur_lost && best_valid && reference_select_mode == ris_pkg::RIS_MODE_AUTO_HOLD
    |=> ref_switch_o && sel_r == $past(best_idx))
    else $error("hold-off expiry did not switch");

  a_revert_pick: assert property (state_r == ris_pkg::RIS_ST_AUTO && reference_select_mode[0]
    && !cur_lost && revert_req |=> sel_r == $past(best_idx))
    else $error("revertive switch missed");

  a_mask_blocks: assert property (mask_ref_loss && !pll_lock_loss_i |=> !vcxo_lock_loss_live_o
    && lock_o)
    else $error("masked reference loss reached lock flags");

  a_ref_loss_flag: assert property (!mask_ref_loss && cur_lost |=> vcxo_lock_loss_live_o
    ##0 vcxo_lock_loss_sticky_o)
    else $error("reference loss did not raise lock-loss flags");

endmodule : ris_reference_input_selector

// file: tb/ris_clock_sources.sv
`timescale 1ns/10ps

module ris_clock_sources (
  input wire logic [3:0] run_i,
  output logic [3:0] ref_clk_o,
  output logic vcxo_clk_o
);
  ////////////////////////////////////////////////////////////////////////
  // VCXO runs free; 24 ns keeps it well inside what 250 MHz sampling resolves
  initial
  begin
    vcxo_clk_o = 1'b0;
    forever #12.0 vcxo_clk_o = ~vcxo_clk_o;
  end

  ////////////////////////////////////////////////////////////////////////
  // Four 25 MHz sources, phases staggered; a stopped source holds low
  for (genvar g = 0; g < 4; g++)
  begin : g_src
    logic ph_r = 1'b0;
    initial
    begin
      #(3.3 * g + 1.0);
      forever #20.0 ph_r = ~ph_r;
    end
    assign ref_clk_o[g] = ph_r & run_i[g];
  end
endmodule : ris_clock_sources

// file: tb/tb_reference_input_selector.sv
`timescale 1ns/10ps

module tb_reference_input_selector;
  logic clk_i;
  logic srst_i;
  logic [3:0] ref_clk;
  logic [3:0] run;
  logic vcxo_clk;
  logic pll_lock_loss;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_we;
  logic reg_re;
  logic [7:0] reg_rdata;
  logic [1:0] ref_select;
  logic ref_switch;
  logic [3:0] sig_loss;
  logic lol_live;
  logic lol_sticky;
  logic lock;
  logic [7:0] rd;
  int err_total;
  int checked;
  int sw_cnt;
  int n;

  ris_clock_sources src (.run_i(run), .ref_clk_o(ref_clk), .vcxo_clk_o(vcxo_clk));

  // Short miss window and prescaler keep the run to a few thousand cycles
  ris_reference_input_selector #(.MISS_CYCLES(16), .PRESCALE_BASE_LOG2(2)) dut (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .ref_clk_i(ref_clk),
    .vcxo_clk_i(vcxo_clk),
    .pll_lock_loss_i(pll_lock_loss),
    .reg_addr_i(reg_addr),
    .reg_wdata_i(reg_wdata),
    .reg_we_i(reg_we),
    .reg_re_i(reg_re),
    .reg_rdata_o(reg_rdata),
    .ref_select_o(ref_select),
    .ref_switch_o(ref_switch),
    .input_signal_loss_o(sig_loss),
    .vcxo_lock_loss_live_o(lol_live),
    .vcxo_lock_loss_sticky_o(lol_sticky),
    .lock_o(lock)
  );

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk_i = 1'b0;
    forever #2.0 clk_i = ~clk_i;
  end

  always @(posedge clk_i)
    if (ref_switch === 1'b1)
      sw_cnt++;

  ////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    if (err_total == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : test_done

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic tick(input int k);
    repeat (k) @(posedge clk_i);
    #1;
  endtask : tick

  // One idle edge after each access so the next call never re-raises a strobe at once
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_we = 1'b1;
    tick(1);
    reg_we = 1'b0;
    tick(1);
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] a);
    reg_addr = a;
    reg_re = 1'b1;
    tick(1);
    rd = reg_rdata;
    reg_re = 1'b0;
    tick(1);
  endtask : reg_rd

  task automatic wait_sel(input logic [1:0] exp, input int lim);
    n = 0;
    while (ref_select !== exp && n < lim)
    begin
      tick(1);
      n++;
    end
    chk({6'h00, ref_select}, {6'h00, exp});
  endtask : wait_sel

  task automatic wait_loss(input logic [3:0] exp, input int lim);
    n = 0;
    while (sig_loss !== exp && n < lim)
    begin
      tick(1);
      n++;
    end
    chk({4'h0, sig_loss}, {4'h0, exp});
  endtask : wait_loss

  // Hold-off of 4 steps of 16 VCXO edges is about 384 cycles plus loss detection
  task automatic wait_switch();
    int s0;
    s0 = sw_cnt;
    n = 0;
    while (sw_cnt == s0 && n < 1000)
    begin
      tick(1);
      n++;
    end
    chk(8'(n >= 200 && n <= 600), 8'h01);
  endtask : wait_switch

  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk({4'h0, sig_loss}, 8'h0F);
    reg_rd(8'h14);
    chk(rd, 8'hE4);
    reg_rd(8'h15);
    chk(rd, 8'h00);
    reg_rd(8'h16);
    chk(rd, 8'h80);
    reg_rd(8'h17);
    chk(rd, 8'h82);
    reg_rd(8'h33);
    chk(rd, 8'h00);
  endtask : t_reset

  // Input 3 powered down, input 2 loses edges mid re-validation
  task automatic t_reval();
    reg_wr(8'h17, 8'hA2);
    tick(130);
    run[2] = 1'b0;
    tick(40);
    chk({4'h0, sig_loss}, 8'h0F);
    run[2] = 1'b1;
    wait_loss(4'hC, 400);
    wait_loss(4'h8, 400);
  endtask : t_reval

  task automatic t_manual();
    logic [1:0] m;
    for (int i = 0; i < 8; i++)
    begin
      m = (i < 4) ? 2'b00 : 2'b10;
      reg_wr(8'h15, {4'h0, m, 2'(i)});
      wait_sel(2'(i), 8);
    end
  endtask : t_manual

  // Selected input 3 is down, so lock-loss depends on the mask
  task automatic t_mask();
    tick(4);
    chk({6'h00, lol_live, lock}, 8'h02);
    reg_wr(8'h15, 8'h4B);
    tick(4);
    chk({6'h00, lol_live, lock}, 8'h01);
    pll_lock_loss = 1'b1;
    tick(4);
    chk({6'h00, lol_live, lock}, 8'h02);
    pll_lock_loss = 1'b0;
    tick(4);
    chk({7'h00, lol_sticky}, 8'h01);
    // A loss in the clearing cycle must keep the sticky flag
    pll_lock_loss = 1'b1;
    reg_wr(8'h1D, 8'h40);
    chk({7'h00, lol_sticky}, 8'h01);
    pll_lock_loss = 1'b0;
    reg_wr(8'h1D, 8'h40);
    chk({7'h00, lol_sticky}, 8'h00);
    reg_rd(8'h1D);
    chk(rd, 8'h38);
  endtask : t_mask

  task automatic t_auto();
    int s0;
    reg_wr(8'h17, 8'h82);
    reg_wr(8'h14, 8'h7C);
    reg_wr(8'h15, 8'h07);
    wait_sel(2'd1, 8);
    s0 = sw_cnt;
    run[1] = 1'b0;
    wait_sel(2'd2, 100);
    chk(8'(sw_cnt - s0), 8'h01);
  endtask : t_auto

  // Input 1 outranks input 2 by order only after re-validation
  task automatic t_revert();
    reg_wr(8'h15, 8'h15);
    run[1] = 1'b1;
    wait_sel(2'd1, 600);
    run[2] = 1'b0;
    tick(40);
    run[2] = 1'b1;
    tick(450);
    chk({6'h00, ref_select}, 8'h01);
  endtask : t_revert

  task automatic t_hold();
    reg_wr(8'h16, 8'h04);
    reg_wr(8'h15, 8'h0D);
    run[1] = 1'b0;
    wait_switch();
    tick(2);
    chk({6'h00, ref_select}, 8'h02);
    run[2] = 1'b0;
    wait_switch();
    tick(2);
    chk({6'h00, ref_select}, 8'h00);
    reg_rd(8'h16);
    chk(rd, 8'h04);
  endtask : t_hold

  // Pre-divide: 32 counted periods need 128 input edges, about 1280 cycles
  task automatic t_prediv();
    reg_wr(8'h15, 8'h20);
    reg_wr(8'h17, 8'hA2);
    reg_wr(8'h17, 8'h82);
    tick(600);
    chk({7'h00, sig_loss[3]}, 8'h01);
    n = 0;
    while (sig_loss[3] !== 1'b0 && n < 1000)
    begin
      tick(1);
      n++;
    end
    chk({7'h00, sig_loss[3]}, 8'h00);
  endtask : t_prediv

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    srst_i = 1'b1;
    run = 4'hF;
    pll_lock_loss = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_we = 1'b0;
    reg_re = 1'b0;
    err_total = 0;
    checked = 0;
    sw_cnt = 0;
    tick(16);
    srst_i = 1'b0;
    t_reset();
    t_reval();
    t_manual();
    t_mask();
    t_auto();
    t_revert();
    t_hold();
    t_prediv();
    test_done();
  end

  // Whole sequence needs about 3600 cycles; 20000 leaves ample margin
  initial
  begin
    #80000.0;
    err_total++;
    test_done();
  end
endmodule : tb_reference_input_selector
